/* File: hdl/gpmc_pkg.sv */
/*
  Shared constants of the port block.
  Assumes one 32-bit word per register: byte address is four times the index.
*/
package gpmc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus and port geometry.
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned ADDR_W     = 6;
  localparam int unsigned IDX_W      = 4;
  localparam int unsigned PORT_W     = 8;
  localparam int unsigned PORT_COUNT = 4;
  localparam int unsigned IRQ_COUNT  = 4;
  localparam int unsigned SYNC_W     = PORT_W * PORT_COUNT;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices: data even, direction odd.
  localparam logic [IDX_W-1:0] IDX_PORT_A_DATA      = 4'h0;
  localparam logic [IDX_W-1:0] IDX_PORT_A_DIRECTION = 4'h1;
  localparam logic [IDX_W-1:0] IDX_PORT_B_DATA      = 4'h2;
  localparam logic [IDX_W-1:0] IDX_PORT_B_DIRECTION = 4'h3;
  localparam logic [IDX_W-1:0] IDX_PORT_C_DATA      = 4'h4;
  localparam logic [IDX_W-1:0] IDX_PORT_C_DIRECTION = 4'h5;
  localparam logic [IDX_W-1:0] IDX_PORT_D_DATA      = 4'h6;
  localparam logic [IDX_W-1:0] IDX_PORT_D_DIRECTION = 4'h7;
  localparam logic [IDX_W-1:0] IDX_PIN_IRQ_CONFIG   = 4'h8;
  localparam logic [IDX_W-1:0] IDX_MISC_CONTROL     = 4'h9;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS       = 4'hA;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK         = 4'hB;

  ////////////////////////////////////////////////////////////////////////////
  // Miscellaneous control fields.
  localparam int unsigned      MISC_CLKOUT_BIT = 0;
  localparam int unsigned      MISC_USBIND_BIT = 1;
  localparam int unsigned      MISC_SLOW_BIT   = 2;
  localparam logic [PORT_W-1:0] MISC_ONES      = 8'hF0;

  ////////////////////////////////////////////////////////////////////////////
  // Pin positions of the alternate functions.
  localparam int unsigned PA_CLKOUT_PIN = 0;
  localparam int unsigned PA_SDA_PIN    = 1;
  localparam int unsigned PA_SCL_PIN    = 2;
  localparam int unsigned PB_USBIND_PIN = 1;
  localparam int unsigned PB_IRQ_LSB    = 4;
  localparam int unsigned PC_TX_PIN     = 1;
  localparam int unsigned PC_USBIND_PIN = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and per-port options.
  localparam logic [PORT_W-1:0] PORT_RESET      = 8'h00;
  localparam logic [PORT_W-1:0] PORT_FULL_MASK  = 8'hFF;
  localparam logic [PORT_W-1:0] PORT_C_IMPL     = 8'h07;
  localparam logic [PORT_W-1:0] PORT_C_FIXED    = 8'hF0;
  localparam logic [PORT_W-1:0] PORT_A_OD       = 8'h06;
  localparam logic [PORT_W-1:0] PORT_A_PULLUP   = 8'hF9;
  localparam logic [PORT_W-1:0] PORT_B_PULLUP   = 8'h00;
  localparam logic [PORT_W-1:0] PORT_C_PULLUP   = 8'h07;
  localparam logic [PORT_W-1:0] PORT_D_PULLUP   = 8'hF0;
  localparam logic [IRQ_COUNT-1:0] IRQ_RESET    = 4'h0;

  // Implemented bits of a port.
  function automatic logic [PORT_W-1:0] impl_mask(input int unsigned p);
    impl_mask = (p == 2) ? PORT_C_IMPL : PORT_FULL_MASK;
  endfunction : impl_mask

  // Pull-up option of each port.
  function automatic logic [PORT_W-1:0] pullup_mask(input int unsigned p);
    case (p)
      0:       pullup_mask = PORT_A_PULLUP;
      1:       pullup_mask = PORT_B_PULLUP;
      2:       pullup_mask = PORT_C_PULLUP;
      default: pullup_mask = PORT_D_PULLUP;
    endcase
  endfunction : pullup_mask

endpackage : gpmc_pkg

/* File: hdl/gpmc_sync.sv */
/*
  Two-flop synchroniser for pin levels.
  Assumes independent bits; no word coherency.
*/
module gpmc_sync #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset.
  input  wire logic             clk_in,
  input  wire logic             srst_in,
  // Levels.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  if (WIDTH == 0) begin : g_bad_width
    $error("width must be at least one");
  end

  // First flop feeds only the second flop.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : gpmc_sync

/* File: hdl/gpmc_port.sv */
/*
  One port: latch, direction, pin drivers, read-back.
  Assumes synchronised pins; the parent picks alternate functions.
*/
module gpmc_port #(
  parameter logic [7:0] IMPL_MASK   = 8'hFF,
  parameter logic [7:0] FIXED       = 8'h00,
  parameter logic [7:0] OD_MASK     = 8'h00,
  parameter logic [7:0] PULLUP_MASK = 8'h00
) (
  // Clock and reset.
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  // Register access.
  input  wire logic       data_we_in,
  input  wire logic       dir_we_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] data_out,
  output logic      [7:0] dir_out,
  output logic      [7:0] rdata_out,
  // Pin side.
  input  wire logic [7:0] pin_sync_in,
  input  wire logic [7:0] alt_en_in,
  input  wire logic [7:0] alt_val_in,
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe_n_out,
  output logic      [7:0] pullup_out
);

  logic [7:0] drive_en_w;
  logic [7:0] drive_val_w;

  // Latch takes every write; fixed bits stay.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      data_out <= FIXED;
    end else if (data_we_in) begin
      data_out <= (wdata_in & IMPL_MASK) | (FIXED & ~IMPL_MASK);
    end
  end

  // Direction bits: 0 input, 1 output.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      dir_out <= FIXED;
    end else if (dir_we_in) begin
      dir_out <= (wdata_in & IMPL_MASK) | (FIXED & ~IMPL_MASK);
    end
  end

  // Alternate function wins and drives.
  assign drive_en_w  = (alt_en_in | dir_out) & IMPL_MASK;
  assign drive_val_w = (alt_en_in & alt_val_in) | (~alt_en_in & data_out);

  // Latch for push-pull outputs, pin otherwise (inputs and open-drain outputs).
  assign rdata_out = (~IMPL_MASK & FIXED) |
                     (IMPL_MASK & dir_out & ~OD_MASK & data_out) |
                     (IMPL_MASK & ~(dir_out & ~OD_MASK) & pin_sync_in);

  // Pin drivers; open drain only pulls low.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pin_out      <= '0;
      pin_oe_n_out <= '1;
      pullup_out   <= '0;
    end else begin
      pin_out      <= drive_val_w & ~OD_MASK;
      pin_oe_n_out <= ~(drive_en_w & (~OD_MASK | ~drive_val_w));
      pullup_out   <= PULLUP_MASK & IMPL_MASK & ~drive_en_w;
    end
  end

endmodule : gpmc_port

/* File: hdl/gpmc_top.sv */
/*
  Ports A to D, alternate pin functions, pin
  interrupts and the misc control register.
  Assumes pins are asynchronous and are
  synchronised here; peripheral inputs are synchronous.
  Registers sit on Avalon-MM with waitrequest.
*/
// The Avalon-MM register port is this design's own decision.

// How it works
// - Data writes with byte lane 0 enabled always reach the latch.
// - Data read: latch for outputs, synced pin for inputs.
// - Open-drain outputs read the pin.
// - Direction bit 0 is input, 1 output.
// - Data at even index, direction at next odd.
// - A, B, D reset to zero; C has fixed upper bits.
// - A1, A2: no pull-up, open drain, I2C.
// - B4-B7 are pin interrupts 5-8 when enabled.
// - Slow select: software sets, reset clears, halves CPU rate.
// - USB enable ignores the slow divider.
// - USB indicator on C2, or B1 on small package.
// - Clock-out bit puts CPU clock on A0.
// - Misc upper bits read as one.
// - Alternate output overrides port, forces output.
// - Enabled pin requests are ORed into one.
// - Pin interrupt ignored on output pins.
module gpmc_top (
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // Avalon-MM register slave.
  input  wire logic [5:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Port A pins.
  input  wire logic [7:0]  port_a_pins_in,
  output logic      [7:0]  port_a_pins_out,
  output logic      [7:0]  port_a_pins_oe_n_out,
  output logic      [7:0]  port_a_pullup_out,
  // Port B pins.
  input  wire logic [7:0]  port_b_pins_in,
  output logic      [7:0]  port_b_pins_out,
  output logic      [7:0]  port_b_pins_oe_n_out,
  output logic      [7:0]  port_b_pullup_out,
  // Port C pins.
  input  wire logic [2:0]  port_c_pins_in,
  output logic      [2:0]  port_c_pins_out,
  output logic      [2:0]  port_c_pins_oe_n_out,
  output logic      [2:0]  port_c_pullup_out,
  // Port D pins.
  input  wire logic [7:0]  port_d_pins_in,
  output logic      [7:0]  port_d_pins_out,
  output logic      [7:0]  port_d_pins_oe_n_out,
  output logic      [7:0]  port_d_pullup_out,
  // On-chip peripheral signals.
  input  wire logic        small_package_in,
  input  wire logic        usb_tx_active_in,
  input  wire logic        i2c_enable_in,
  input  wire logic        i2c_sda_drive_in,
  input  wire logic        i2c_scl_drive_in,
  input  wire logic        sci_enable_in,
  input  wire logic        sci_tx_in,
  // Clock enables.
  output logic             cpu_clock_enable_out,
  output logic             usb_clock_enable_out,
  // Interrupts.
  output logic             pin_ext_request_out,
  output logic             irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  localparam int unsigned PW = gpmc_pkg::PORT_W;
  localparam int unsigned NP = gpmc_pkg::PORT_COUNT;
  localparam int unsigned NI = gpmc_pkg::IRQ_COUNT;

  logic                           wait_q;
  logic [31:0]                    rdata_q;
  logic [gpmc_pkg::IDX_W-1:0]     idx_w;
  logic                           rd_take_w;
  logic                           wr_take_w;
  logic [PW-1:0]                  wbyte_w;
  logic [PW-1:0]                  rvalue_w;

  logic [gpmc_pkg::SYNC_W-1:0]    pins_raw_w;
  logic [gpmc_pkg::SYNC_W-1:0]    pins_sync_w;
  logic [NP-1:0][PW-1:0]          pin_sync_w;
  logic [NP-1:0][PW-1:0]          alt_en_w;
  logic [NP-1:0][PW-1:0]          alt_val_w;
  logic [NP-1:0][PW-1:0]          data_w;
  logic [NP-1:0][PW-1:0]          dir_w;
  logic [NP-1:0][PW-1:0]          rd_port_w;
  logic [NP-1:0][PW-1:0]          pin_out_w;
  logic [NP-1:0][PW-1:0]          pin_oe_n_w;
  logic [NP-1:0][PW-1:0]          pullup_w;

  logic                           clkout_en_q;
  logic                           usbind_en_q;
  logic                           slow_sel_q;
  logic                           phase_q;
  logic                           clkout_level_q;
  logic [NI-1:0]                  irq_cfg_q;
  logic [NI-1:0]                  irq_status_q;
  logic [NI-1:0]                  irq_mask_q;
  logic [NI-1:0]                  irq_prev_q;
  logic [NI-1:0]                  irq_pins_w;
  logic [NI-1:0]                  irq_event_w;
  logic [NI-1:0]                  irq_clear_w;

  ////////////////////////////////////////////////////////////////////////////
  // Index match for read and write decode.
  function automatic logic hit(input logic [gpmc_pkg::IDX_W-1:0] idx,
                               input logic [gpmc_pkg::IDX_W-1:0] target);
    hit = (idx == target);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then the answer.
  assign idx_w     = avs_address_in[gpmc_pkg::ADDR_W-1:2];
  assign rd_take_w = avs_read_in & wait_q;
  assign wr_take_w = avs_write_in & ~wait_q & avs_byteenable_in[0];
  assign wbyte_w   = avs_writedata_in[PW-1:0];

  // Wait drops one cycle after a request.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wait_q <= 1'b1;
    end else if ((avs_read_in | avs_write_in) & wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // Addressed register value; unmapped reads give zero.
  always_comb begin
    rvalue_w = '0;
    if (idx_w < gpmc_pkg::IDX_PIN_IRQ_CONFIG) begin
      rvalue_w = idx_w[0] ? dir_w[idx_w[2:1]] : rd_port_w[idx_w[2:1]];
    end else if (hit(idx_w, gpmc_pkg::IDX_PIN_IRQ_CONFIG)) begin
      rvalue_w = {4'h0, irq_cfg_q};
    end else if (hit(idx_w, gpmc_pkg::IDX_MISC_CONTROL)) begin
      rvalue_w = gpmc_pkg::MISC_ONES | {5'h00, slow_sel_q, usbind_en_q, clkout_en_q};
    end else if (hit(idx_w, gpmc_pkg::IDX_IRQ_STATUS)) begin
      rvalue_w = {4'h0, irq_status_q};
    end else if (hit(idx_w, gpmc_pkg::IDX_IRQ_MASK)) begin
      rvalue_w = {4'h0, irq_mask_q};
    end
  end

  // Read data captured in the wait cycle.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_q <= '0;
    end else if (rd_take_w) begin
      rdata_q <= {24'h000000, rvalue_w};
    end
  end

  assign avs_waitrequest_out = wait_q;
  assign avs_readdata_out    = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for all four ports.
  assign pins_raw_w = {port_d_pins_in, 5'h00, port_c_pins_in, port_b_pins_in, port_a_pins_in};

  gpmc_sync #(
    .WIDTH (gpmc_pkg::SYNC_W)
  ) u_sync (
    .clk_in   (clk_in),
    .srst_in  (srst_in),
    .async_in (pins_raw_w),
    .sync_out (pins_sync_w)
  );

  assign pin_sync_w = pins_sync_w;

  ////////////////////////////////////////////////////////////////////////////
  // Alternate functions per pin.
  always_comb begin
    alt_en_w  = '0;
    alt_val_w = '0;
    // Clock out on port A pin 0.
    alt_en_w[0][gpmc_pkg::PA_CLKOUT_PIN]  = clkout_en_q;
    alt_val_w[0][gpmc_pkg::PA_CLKOUT_PIN] = clkout_level_q;
    // I2C on the open-drain pins.
    alt_en_w[0][gpmc_pkg::PA_SDA_PIN]     = i2c_enable_in;
    alt_val_w[0][gpmc_pkg::PA_SDA_PIN]    = i2c_sda_drive_in;
    alt_en_w[0][gpmc_pkg::PA_SCL_PIN]     = i2c_enable_in;
    alt_val_w[0][gpmc_pkg::PA_SCL_PIN]    = i2c_scl_drive_in;
    // USB transmit indicator, pin chosen by package.
    alt_en_w[1][gpmc_pkg::PB_USBIND_PIN]  = usbind_en_q & small_package_in;
    alt_val_w[1][gpmc_pkg::PB_USBIND_PIN] = usb_tx_active_in;
    alt_en_w[2][gpmc_pkg::PC_USBIND_PIN]  = usbind_en_q & ~small_package_in;
    alt_val_w[2][gpmc_pkg::PC_USBIND_PIN] = usb_tx_active_in;
    // Serial transmit output.
    alt_en_w[2][gpmc_pkg::PC_TX_PIN]      = sci_enable_in;
    alt_val_w[2][gpmc_pkg::PC_TX_PIN]     = sci_tx_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // The four ports.
  for (genvar p = 0; p < NP; p++) begin : g_port
    gpmc_port #(
      .IMPL_MASK   (gpmc_pkg::impl_mask(p)),
      .FIXED       ((p == 2) ? gpmc_pkg::PORT_C_FIXED : gpmc_pkg::PORT_RESET),
      .OD_MASK     ((p == 0) ? gpmc_pkg::PORT_A_OD : gpmc_pkg::PORT_RESET),
      .PULLUP_MASK (gpmc_pkg::pullup_mask(p))
    ) u_port (
      .clk_in       (clk_in),
      .srst_in      (srst_in),
      .data_we_in   (wr_take_w && idx_w == 4'(2 * p)),
      .dir_we_in    (wr_take_w && idx_w == 4'(2 * p + 1)),
      .wdata_in     (wbyte_w),
      .data_out     (data_w[p]),
      .dir_out      (dir_w[p]),
      .rdata_out    (rd_port_w[p]),
      .pin_sync_in  (pin_sync_w[p]),
      .alt_en_in    (alt_en_w[p]),
      .alt_val_in   (alt_val_w[p]),
      .pin_out      (pin_out_w[p]),
      .pin_oe_n_out (pin_oe_n_w[p]),
      .pullup_out   (pullup_w[p])
    );
  end

  // Pin outputs come from the port flops.
  assign port_a_pins_out      = pin_out_w[0];
  assign port_a_pins_oe_n_out = pin_oe_n_w[0];
  assign port_a_pullup_out    = pullup_w[0];
  assign port_b_pins_out      = pin_out_w[1];
  assign port_b_pins_oe_n_out = pin_oe_n_w[1];
  assign port_b_pullup_out    = pullup_w[1];
  assign port_c_pins_out      = pin_out_w[2][2:0];
  assign port_c_pins_oe_n_out = pin_oe_n_w[2][2:0];
  assign port_c_pullup_out    = pullup_w[2][2:0];
  assign port_d_pins_out      = pin_out_w[3];
  assign port_d_pins_oe_n_out = pin_oe_n_w[3];
  assign port_d_pullup_out    = pullup_w[3];

  ////////////////////////////////////////////////////////////////////////////
  // Miscellaneous control register.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      clkout_en_q <= 1'b0;
      usbind_en_q <= 1'b0;
    end else if (wr_take_w && hit(idx_w, gpmc_pkg::IDX_MISC_CONTROL)) begin
      clkout_en_q <= wbyte_w[gpmc_pkg::MISC_CLKOUT_BIT];
      usbind_en_q <= wbyte_w[gpmc_pkg::MISC_USBIND_BIT];
    end
  end

  // Slow select is set only; reset alone clears it.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      slow_sel_q <= 1'b0;
    end else if (wr_take_w && hit(idx_w, gpmc_pkg::IDX_MISC_CONTROL) &&
                 wbyte_w[gpmc_pkg::MISC_SLOW_BIT]) begin
      slow_sel_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CPU enable halves in slow mode; USB enable never does.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      phase_q              <= 1'b0;
      cpu_clock_enable_out <= 1'b0;
      usb_clock_enable_out <= 1'b0;
    end else begin
      phase_q              <= ~phase_q;
      cpu_clock_enable_out <= ~slow_sel_q | phase_q;
      usb_clock_enable_out <= 1'b1;
    end
  end

  // Clock-out level toggles on every CPU enable.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      clkout_level_q <= 1'b0;
    end else if (cpu_clock_enable_out) begin
      clkout_level_q <= ~clkout_level_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin interrupts on port B pins 4 to 7, falling edge.
  assign irq_pins_w  = pin_sync_w[1][gpmc_pkg::PB_IRQ_LSB +: NI];
  assign irq_event_w = irq_cfg_q & irq_prev_q & ~irq_pins_w &
                       ~dir_w[1][gpmc_pkg::PB_IRQ_LSB +: NI] &
                       ~alt_en_w[1][gpmc_pkg::PB_IRQ_LSB +: NI];
  assign irq_clear_w = (wr_take_w && hit(idx_w, gpmc_pkg::IDX_IRQ_STATUS)) ?
                       wbyte_w[NI-1:0] : '0;

  // Last synchronised level, for edges.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_prev_q <= '0;
    end else begin
      irq_prev_q <= irq_pins_w;
    end
  end

  // Interrupt enable register.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_cfg_q <= gpmc_pkg::IRQ_RESET;
    end else if (wr_take_w && hit(idx_w, gpmc_pkg::IDX_PIN_IRQ_CONFIG)) begin
      irq_cfg_q <= wbyte_w[NI-1:0];
    end
  end

  // Mask register.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_mask_q <= gpmc_pkg::IRQ_RESET;
    end else if (wr_take_w && hit(idx_w, gpmc_pkg::IDX_IRQ_MASK)) begin
      irq_mask_q <= wbyte_w[NI-1:0];
    end
  end

  // Sticky status, write one to clear; a new event beats the clear.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_status_q <= gpmc_pkg::IRQ_RESET;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clear_w) | irq_event_w;
    end
  end

  // Combined pin request and masked interrupt.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pin_ext_request_out <= 1'b0;
      irq_out             <= 1'b0;
    end else begin
      pin_ext_request_out <= |irq_event_w;
      irq_out             <= |(irq_status_q & irq_mask_q);
    end
  end

endmodule : gpmc_top

/* File: verification/gpmc_chk.sv */
/* Checker for the port block, on its top ports only.
   Assumes one clock, synchronous active-high reset. */
module gpmc_chk (
  // Clock and reset.
  input wire logic        clk_in,
  input wire logic        srst_in,
  // Register bus.
  input wire logic [5:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  // Pins, clock enables and the pin request.
  input wire logic [7:0]  port_a_pins_out,
  input wire logic [7:0]  port_a_pullup_out,
  input wire logic [7:0]  port_b_pins_in,
  input wire logic [7:0]  port_b_pullup_out,
  input wire logic [7:0]  port_d_pullup_out,
  input wire logic        cpu_clock_enable_out,
  input wire logic        usb_clock_enable_out,
  input wire logic        pin_ext_request_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  logic [3:0] b_prev_q;
  logic [7:0] fall_q;
  ////////////////////////////////////////////////////////////////////////////
  // Falls on the raw interrupt pins, last eight cycles.
  always_ff @(posedge clk_in) begin
    b_prev_q <= port_b_pins_in[7:4];
    fall_q   <= srst_in ? 8'h00 : {fall_q[6:0], |(b_prev_q & ~port_b_pins_in[7:4])};
  end
  // A read that completes in this cycle.
  sequence rd_end;
    avs_read_in && !avs_waitrequest_out;
  endsequence
  chk_wait_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("request not answered");
  chk_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("wait low too long");
  chk_unmapped_zero: assert property (rd_end ##0 (avs_address_in[5:4] == 2'h3)
    |-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
  chk_misc_ones: assert property (rd_end ##0 (avs_address_in[5:2] == 4'h9)
    |-> avs_readdata_out[7:4] == 4'hF) else $error("misc upper bits not one");
  chk_portc_fixed: assert property (rd_end ##0 (avs_address_in[5:3] == 3'h2)
    |-> avs_readdata_out[7:3] == 5'h1E) else $error("port C fixed bits wrong");
  chk_cpu_rate: assert property (!srst_in [*4] ##0 !cpu_clock_enable_out
    |=> cpu_clock_enable_out) else $error("cpu enable missing twice");
  chk_usb_rate: assert property (!srst_in [*4] |-> usb_clock_enable_out)
    else $error("usb enable dropped");
  chk_ext_cause: assert property (pin_ext_request_out |-> fall_q != 8'h00)
    else $error("pin request without a fall");
  chk_pull_mask: assert property (port_b_pullup_out == 8'h00
    && port_d_pullup_out[3:0] == 4'h0 && port_a_pullup_out[2:1] == 2'h0
    && port_a_pins_out[2:1] == 2'h0) else $error("pull mask");
endmodule : gpmc_chk

bind gpmc_top gpmc_chk u_chk (.*);

/* File: verification/gpmc_pins.sv */
/* Board model of one port's pins.
   Assumes a board level that a driving pin overrides. */
module gpmc_pins #(
  parameter int unsigned W  = 8,
  parameter logic [W-1:0] OD = '0
) (
  input  wire logic [W-1:0] ext_in,
  input  wire logic [W-1:0] out_in,
  input  wire logic [W-1:0] oe_n_in,
  output logic      [W-1:0] lvl_out
);
  // Push-pull drive wins; open-drain only pulls low; released pins show the board.
  assign lvl_out = (oe_n_in & ext_in) | (~oe_n_in & out_in & (~OD | ext_in));
endmodule : gpmc_pins

/* File: verification/tb_top.sv */
/* Self-checking bench, board model on each port.
   Assumes the checker binds itself. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in, srst_in, avs_read_in, avs_write_in, avs_waitrequest_out, irq_out;
  logic [5:0] avs_address_in;
  logic [3:0] avs_byteenable_in;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  logic [7:0] port_a_pins_in, port_a_pins_out, port_a_pins_oe_n_out, port_a_pullup_out, ext_a;
  logic [7:0] port_b_pins_in, port_b_pins_out, port_b_pins_oe_n_out, port_b_pullup_out, ext_b;
  logic [2:0] port_c_pins_in, port_c_pins_out, port_c_pins_oe_n_out, port_c_pullup_out, ext_c;
  logic [7:0] port_d_pins_in, port_d_pins_out, port_d_pins_oe_n_out, port_d_pullup_out, ext_d;
  logic small_package_in, usb_tx_active_in, i2c_enable_in, i2c_sda_drive_in, i2c_scl_drive_in;
  logic sci_enable_in, sci_tx_in, cpu_clock_enable_out, usb_clock_enable_out, pin_ext_request_out;
  int bad_count, checks, cyc;
  gpmc_top DUT (.*);
  gpmc_pins #(.OD(8'h06)) pa (.ext_in(ext_a), .out_in(port_a_pins_out),
    .oe_n_in(port_a_pins_oe_n_out), .lvl_out(port_a_pins_in));
  gpmc_pins pb (.ext_in(ext_b), .out_in(port_b_pins_out),
    .oe_n_in(port_b_pins_oe_n_out), .lvl_out(port_b_pins_in));
  gpmc_pins #(.W(3)) pc (.ext_in(ext_c), .out_in(port_c_pins_out),
    .oe_n_in(port_c_pins_oe_n_out), .lvl_out(port_c_pins_in));
  gpmc_pins pd (.ext_in(ext_d), .out_in(port_d_pins_out),
    .oe_n_in(port_d_pins_oe_n_out), .lvl_out(port_d_pins_in));
  ////////////////////////////////////////////////////////////////////////////
  // Counts mismatches and comparisons.
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (bad_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  // One transfer, held until wait is seen low.
  task automatic xfer(input logic w, input logic [3:0] i, input logic [7:0] d,
                      output logic [31:0] q);
    @(posedge clk_in);
    avs_address_in   <= {i, 2'h0};
    avs_writedata_in <= {24'h0, d};
    avs_write_in     <= w;
    avs_read_in      <= ~w;
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, i, d, q);
  endtask : wr
  // Waits out the synchroniser, reads, compares.
  task automatic rc(input logic [3:0] i, input logic [7:0] e);
    logic [31:0] q;
    repeat (4) @(posedge clk_in);
    xfer(1'b0, i, 8'h00, q);
    cmp("readdata", {24'h0, e}, q);
  endtask : rc
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    // Input pins read the board level: data reads show the pins, not the latch.
    for (int i = 0; i < 8; i++)
      rc(4'(i), (i == 4) ? 8'hF7 : (i == 5) ? 8'hF0 : i[0] ? 8'h00 : 8'hFF);
    rc(4'h9, 8'hF0);
  endtask : t_reset
  task automatic t_dir();
    ext_b <= 8'h3C;
    wr(4'h2, 8'hA5);
    rc(4'h2, 8'h3C);
    wr(4'h3, 8'hFF);
    repeat (2) @(posedge clk_in);
    cmp("port_b_oe_n", 32'h00, 32'(port_b_pins_oe_n_out));
    cmp("port_b_out", 32'hA5, 32'(port_b_pins_out));
    wr(4'h3, 8'h0F);
    rc(4'h3, 8'h0F);
    rc(4'h2, 8'h35);
  endtask : t_dir
  task automatic t_od();
    ext_a <= 8'hF9;
    wr(4'h0, 8'h06);
    wr(4'h1, 8'h06);
    rc(4'h0, 8'hF9);
    cmp("port_a_pullup", 32'hF9, 32'(port_a_pullup_out));
  endtask : t_od
  task automatic t_portc();
    wr(4'h4, 8'hFF);
    wr(4'h5, 8'hFF);
    avs_byteenable_in <= 4'h0;
    wr(4'h4, 8'h00);
    avs_byteenable_in <= 4'hF;
    rc(4'h4, 8'hF7);
    rc(4'h5, 8'hF7);
    wr(4'hC, 8'hFF);
    rc(4'hC, 8'h00);
  endtask : t_portc
  task automatic t_irq();
    wr(4'h3, 8'h00);
    ext_b <= 8'hFF;
    wr(4'h8, 8'h01);
    ext_b <= 8'hEF;
    repeat (6) @(posedge clk_in);
    cmp("irq_masked", 32'h0, 32'(irq_out));
    rc(4'hA, 8'h01);
    wr(4'hB, 8'h01);
    repeat (2) @(posedge clk_in);
    cmp("irq_raised", 32'h1, 32'(irq_out));
    wr(4'hA, 8'h01);
    ext_b <= 8'hFF;
    repeat (3) @(posedge clk_in);
    cmp("irq_cleared", 32'h0, 32'(irq_out));
    wr(4'h3, 8'h10);
    rc(4'hA, 8'h00);
  endtask : t_irq
  task automatic t_alt();
    logic [31:0] n;
    wr(4'h5, 8'h00);
    wr(4'h9, 8'h03);
    repeat (2) @(posedge clk_in);
    cmp("port_c_oe_n", 32'h3, 32'(port_c_pins_oe_n_out));
    cmp("port_c_usb", 32'h0, 32'(port_c_pins_out[2]));
    cmp("port_a_clk_oe_n", 32'h0, 32'(port_a_pins_oe_n_out[0]));
    usb_tx_active_in <= 1'b1;
    small_package_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    cmp("port_b_usb", 32'h1, 32'(port_b_pins_out[1]));
    wr(4'h9, 8'h07);
    rc(4'h9, 8'hF7);
    wr(4'h9, 8'h00);
    rc(4'h9, 8'hF4);
    n = 32'h0;
    repeat (10) begin
      @(posedge clk_in);
      n = n + 32'(cpu_clock_enable_out);
    end
    cmp("cpu_enables", 32'h5, n);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    rc(4'h9, 8'hF0);
  endtask : t_alt
  ////////////////////////////////////////////////////////////////////////////
  // Free-running clock of 100 ns.
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // Cuts a hang short.
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // Idle values, 12 cycles of reset, scenarios.
  initial begin
    {avs_read_in, avs_write_in, small_package_in, usb_tx_active_in} = 4'h0;
    {i2c_enable_in, i2c_sda_drive_in, i2c_scl_drive_in, sci_enable_in, sci_tx_in} = 5'h00;
    {avs_address_in, avs_writedata_in, avs_byteenable_in} = {6'h00, 32'h0, 4'hF};
    {ext_a, ext_b, ext_c, ext_d} = {8'hFF, 8'hFF, 3'h7, 8'hFF};
    srst_in = 1'b1;
    repeat (12) @(posedge clk_in);
    srst_in <= 1'b0;
    t_reset();
    t_dir();
    t_od();
    t_portc();
    t_irq();
    t_alt();
    report_and_stop();
  end
endmodule : tb_top
